/* File: hdl/eof_pkg.sv */
package eof_pkg;

  // Datapath word and bit positions
  localparam int unsigned EOF_WORD_W = 16;
  localparam int unsigned EOF_MSB    = 15;
  localparam int unsigned EOF_LSB    = 0;

  // Instruction-word fields used by the flag decoders
  localparam int unsigned EOF_HI_B2  = 8;
  localparam int unsigned EOF_HI_B1  = 7;
  localparam int unsigned EOF_HI_B0  = 6;
  localparam int unsigned EOF_LO_B2  = 2;
  localparam int unsigned EOF_LO_B1  = 1;
  localparam int unsigned EOF_LO_B0  = 0;

  // Flag values after reset
  localparam logic EOF_EXT_RST = 1'b0;
  localparam logic EOF_OVF_RST = 1'b0;

endpackage : eof_pkg

/* File: hdl/eof_two_rank.sv */
`timescale 1ns/1ns
// Two-rank flag: input rank loads on strobe rise, output rank on strobe fall
module eof_two_rank
  import eof_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic strobe,
  input  wire logic set_in,
  input  wire logic clear_in,
  input  wire logic data_en,
  input  wire logic data_in,
  output logic      q
);

  typedef struct packed {
    logic strobe_d;
    logic rank;
    logic q;
  } eof_rank_type;

  eof_rank_type s;
  eof_rank_type next_s;

  // Data load beats set/clear; set and clear together toggle
  always_comb begin
    next_s          = s;
    next_s.strobe_d = strobe;
    if (strobe && !s.strobe_d) begin
      if (data_en) begin
        next_s.rank = data_in;
      end else if (set_in && clear_in) begin
        next_s.rank = !s.q;
      end else if (set_in) begin
        next_s.rank = 1'b1;
      end else if (clear_in) begin
        next_s.rank = 1'b0;
      end else begin
        next_s.rank = s.q;
      end
    end
    if (!strobe && s.strobe_d) begin
      next_s.q = s.rank;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{strobe_d: 1'b0, rank: RST_VAL, q: RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule : eof_two_rank

/* File: hdl/eof_overflow_detect.sv */
`timescale 1ns/1ns
// Sign-based overflow detection on the adder buses
module eof_overflow_detect (
  input  wire logic r_sign,
  input  wire logic s_sign,
  input  wire logic t_sign,
  output logic      pos_ovf,
  output logic      neg_ovf
);

  // Two positives giving negative, two negatives giving positive
  assign pos_ovf = !r_sign && !s_sign && t_sign;
  assign neg_ovf = r_sign && s_sign && !t_sign;

endmodule : eof_overflow_detect

/* File: hdl/eof_flag_logic.sv */
`timescale 1ns/1ns
module eof_flag_logic
  import eof_pkg::*;
#(
  parameter int unsigned WORD_W = EOF_WORD_W
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [WORD_W-1:0] instr,
  input  wire logic              shift_rotate_group_decoded,
  input  wire logic              rotate_right_through_extend,
  input  wire logic              add_memory_to_accumulator,
  input  wire logic              increment_accumulator,
  input  wire logic              increment_memory_skip_zero,
  input  wire logic              set_extend_flag,
  input  wire logic              zero_extend_shift,
  input  wire logic              zero_extend_alter,
  input  wire logic              invert_extend_flag,
  input  wire logic              zero_overflow_flag,
  input  wire logic              io_switch_address_select,
  input  wire logic              skip_if_overflow_set,
  input  wire logic              skip_if_overflow_clear,
  input  wire logic              phase_three,
  input  wire logic              transfer_strobe,
  input  wire logic              write_result_to_acc_a,
  input  wire logic              write_result_to_acc_b,
  input  wire logic              carry_out_msb,
  input  wire logic [WORD_W-1:0] r_bus,
  input  wire logic [WORD_W-1:0] s_bus,
  input  wire logic [WORD_W-1:0] t_bus,
  output logic                   result_fill_bit,
  output logic                   result_fill_lsb,
  output logic                   result_fill_msb,
  output logic                   skip_request,
  output logic                   extend_lamp,
  output logic                   overflow_lamp
);

  // Word width must match the sixteen-bit flag positions
  if (WORD_W != EOF_WORD_W) begin : g_width_check
    $error("eof_flag_logic: WORD_W must be 16");
  end

  // Strobe tracking plus a snapshot of each cause taken at strobe start
  typedef struct packed {
    logic strb_d;
    logic chk;
    logic h_ext;
    logic h_ovf;
    logic h_rotl;
    logic h_rotr;
    logic h_r15;
    logic h_r0;
    logic h_carry;
    logic h_set;
    logic h_clr;
    logic h_inv;
    logic h_oset;
    logic h_oclr;
  } eof_state_type;

  eof_state_type s;
  eof_state_type next_s;

  logic phase_three_transfer_strobe;
  logic strb_rise;
  logic strb_fall;
  logic rotate_left_through_extend;
  logic rot_act;
  logic rot_data;
  logic arith_act;
  logic carry_set;
  logic ext_set_plain;
  logic ext_clr_plain;
  logic ext_set;
  logic ext_clr;
  logic pos_ovf;
  logic neg_ovf;
  logic set_overflow_flag;
  logic ovf_set;
  logic ovf_clr;
  logic extend_q;
  logic overflow_q;
  logic store_acc;

  // Strobe within phase three and its edges
  assign phase_three_transfer_strobe = phase_three && transfer_strobe;
  assign strb_rise = phase_three_transfer_strobe && !s.strb_d;
  assign strb_fall = !phase_three_transfer_strobe && s.strb_d;

  // Rotate-left decode from either bit group
  assign rotate_left_through_extend = shift_rotate_group_decoded &&
    ((instr[EOF_HI_B2] && instr[EOF_HI_B1] && !instr[EOF_HI_B0]) ||
     (instr[EOF_LO_B2] && instr[EOF_LO_B1] && !instr[EOF_LO_B0]));

  // Rotates load extend from the shifted-out bit on R bus
  assign rot_act  = phase_three && (rotate_left_through_extend ||
                    (shift_rotate_group_decoded && rotate_right_through_extend));
  assign rot_data = rotate_left_through_extend ? r_bus[EOF_MSB]
                                               : r_bus[EOF_LSB];

  // Add or increment, never memory increment-skip
  assign arith_act = (add_memory_to_accumulator || increment_accumulator) &&
                     !increment_memory_skip_zero;
  assign carry_set = arith_act && carry_out_msb;

  // Extend set/clear; a set wins over a plain clear, both means invert
  assign ext_set_plain = set_extend_flag || carry_set;
  assign ext_clr_plain = zero_extend_shift || zero_extend_alter;
  assign ext_set = phase_three && (ext_set_plain || invert_extend_flag);
  assign ext_clr = phase_three && (invert_extend_flag ||
                   (ext_clr_plain && !ext_set_plain));

  // Extend flag storage
  eof_two_rank #(
    .RST_VAL (EOF_EXT_RST)
  ) u_extend (
    .clk      (clk),
    .rst_b    (rst_b),
    .strobe   (phase_three_transfer_strobe),
    .set_in   (ext_set),
    .clear_in (ext_clr),
    .data_en  (rot_act),
    .data_in  (rot_data),
    .q        (extend_q)
  );

  // Sign checks on R, S and T bus bit 15
  eof_overflow_detect u_ovf_det (
    .r_sign  (r_bus[EOF_MSB]),
    .s_sign  (s_bus[EOF_MSB]),
    .t_sign  (t_bus[EOF_MSB]),
    .pos_ovf (pos_ovf),
    .neg_ovf (neg_ovf)
  );

  // Overflow set sources; set wins over a simultaneous clear
  assign set_overflow_flag = !instr[EOF_HI_B2] && !instr[EOF_HI_B1] &&
                             instr[EOF_HI_B0] && io_switch_address_select;
  assign ovf_set = phase_three &&
                   ((arith_act && (pos_ovf || neg_ovf)) || set_overflow_flag);
  assign ovf_clr = phase_three && zero_overflow_flag && !ovf_set;

  // Overflow flag storage, sticky between clears
  eof_two_rank #(
    .RST_VAL (EOF_OVF_RST)
  ) u_overflow (
    .clk      (clk),
    .rst_b    (rst_b),
    .strobe   (phase_three_transfer_strobe),
    .set_in   (ovf_set),
    .clear_in (ovf_clr),
    .data_en  (1'b0),
    .data_in  (1'b0),
    .q        (overflow_q)
  );

  // Old extend offered to result bus during the accumulator store
  assign store_acc       = write_result_to_acc_a || write_result_to_acc_b;
  assign result_fill_bit = extend_q;
  assign result_fill_lsb = phase_three_transfer_strobe && store_acc &&
                           rotate_left_through_extend;
  assign result_fill_msb = phase_three_transfer_strobe && store_acc &&
                           shift_rotate_group_decoded && rotate_right_through_extend;

  // Skip sense on overflow
  assign skip_request = (skip_if_overflow_set && overflow_q) ||
                        (skip_if_overflow_clear && !overflow_q);

  // Front-panel lamps
  assign extend_lamp   = extend_q;
  assign overflow_lamp = overflow_q;

  // Snapshot of causes at strobe start, check flag one cycle after the end
  always_comb begin
    next_s        = s;
    next_s.strb_d = phase_three_transfer_strobe;
    next_s.chk    = strb_fall;
    if (strb_rise) begin
      next_s.h_ext   = extend_q;
      next_s.h_ovf   = overflow_q;
      next_s.h_rotl  = rot_act && rotate_left_through_extend;
      next_s.h_rotr  = rot_act && !rotate_left_through_extend;
      next_s.h_r15   = r_bus[EOF_MSB];
      next_s.h_r0    = r_bus[EOF_LSB];
      next_s.h_carry = carry_set;
      next_s.h_set   = ext_set;
      next_s.h_clr   = ext_clr;
      next_s.h_inv   = invert_extend_flag;
      next_s.h_oset  = ovf_set;
      next_s.h_oclr  = ovf_clr;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Extend moves only right after a strobe end
  a_ext_two_rank: assert property (
    $changed(extend_q) |-> s.chk)
    else $error("extend changed away from strobe end");

  // Rotate left loads old bit 15
  a_rotl_capture: assert property (
    (s.chk && s.h_rotl) |-> (extend_q == s.h_r15))
    else $error("rotate left did not capture bit 15");

  // Rotate right loads old bit 0
  a_rotr_capture: assert property (
    (s.chk && s.h_rotr) |-> (extend_q == s.h_r0))
    else $error("rotate right did not capture bit 0");

  // Carry sets extend
  a_carry_sets: assert property (
    (s.chk && s.h_carry && !s.h_inv && !s.h_rotl && !s.h_rotr) |-> extend_q)
    else $error("carry did not set extend");

  // No extend cause leaves it unchanged
  a_ext_hold: assert property (
    (s.chk && !s.h_set && !s.h_clr && !s.h_rotl && !s.h_rotr)
      |-> (extend_q == s.h_ext))
    else $error("extend changed without cause");

  // Invert toggles extend
  a_ext_invert: assert property (
    (s.chk && s.h_inv && !s.h_rotl && !s.h_rotr) |-> (extend_q != s.h_ext))
    else $error("invert did not toggle extend");

  // Plain clear zeroes extend
  a_ext_clear: assert property (
    (s.chk && s.h_clr && !s.h_set && !s.h_rotl && !s.h_rotr) |-> !extend_q)
    else $error("clear did not zero extend");

  // Overflow set causes
  a_ovf_sets: assert property (
    (s.chk && s.h_oset) |-> overflow_q)
    else $error("overflow not set");

  // Overflow clear
  a_ovf_clears: assert property (
    (s.chk && s.h_oclr) |-> !overflow_q)
    else $error("overflow not cleared");

  // Overflow sticky otherwise
  a_ovf_sticky: assert property (
    (s.chk && !s.h_oset && !s.h_oclr) |-> (overflow_q == s.h_ovf))
    else $error("overflow changed without cause");

  // Fill only during the phase-three store
  a_fill_timing: assert property (
    (result_fill_lsb || result_fill_msb) |-> (phase_three && transfer_strobe && store_acc))
    else $error("fill enable outside store");

  // Skip follows the overflow lamp for each test
  a_skip_when_set: assert property (
    (skip_if_overflow_set && overflow_lamp) |-> skip_request)
    else $error("no skip on overflow set");

  a_skip_when_clear: assert property (
    (skip_if_overflow_clear && !overflow_lamp) |-> skip_request)
    else $error("no skip on overflow clear");

  // No skip test, no skip request
  a_skip_idle: assert property (
    (!skip_if_overflow_set && !skip_if_overflow_clear) |-> !skip_request)
    else $error("skip without a test");

  c_rotl: cover property (s.chk && s.h_rotl && (s.h_r15 != s.h_ext));
  c_carry: cover property (s.chk && s.h_carry);
  c_invert: cover property (s.chk && s.h_inv);
  c_ovf_set: cover property (s.chk && s.h_oset && !s.h_ovf);
  c_skip: cover property (skip_request && skip_if_overflow_set);

endmodule : eof_flag_logic

/* File: sim/eof_phase_model.sv */
`timescale 1ns/1ns
// Timing generator model: one phase three holding a single transfer strobe per request
module eof_phase_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic go,
  output logic      phase_three,
  output logic      transfer_strobe
);
  logic [2:0] step;

  // Step 1 opens phase three, step 2 strobes, step 3 closes it, step 4 idles once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step <= 3'h0;
    end else if (step != 3'h0) begin
      step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
    end else if (go) begin
      step <= 3'h1;
    end
  end

  // Strobe lies inside phase three, low before and after it
  assign phase_three     = (step != 3'h0) && (step != 3'h4);
  assign transfer_strobe = (step == 3'h2);
endmodule : eof_phase_model

/* File: sim/tb_extend_overflow_flag_logic.sv */
`timescale 1ns/1ns
module tb_extend_overflow_flag_logic
  import eof_pkg::*;
;
  // One mask bit per decoded control input
  localparam logic [14:0] GRP = 15'h0001, RR = 15'h0002, ADD = 15'h0004, INC = 15'h0008;
  localparam logic [14:0] MIS = 15'h0010, SE = 15'h0020, ZES = 15'h0040, ZEA = 15'h0080;
  localparam logic [14:0] INV = 15'h0100, ZO = 15'h0200, IOA = 15'h0400, WA = 15'h0800;
  localparam logic [14:0] WB  = 15'h1000, SKS = 15'h2000, SKC = 15'h4000;

  logic        clk, rst_b, go, carry, p3, strb;
  logic [14:0] ctl;
  logic [15:0] instr, r_bus, s_bus, t_bus;
  logic        fill_bit, fill_lsb, fill_msb, skip, ext, ovf;
  logic        s_bit, s_lsb, s_msb, s_skip, s_mid;
  int          bad_count, compares, cycles;

  eof_phase_model phase (.clk(clk), .rst_b(rst_b), .go(go), .phase_three(p3),
                         .transfer_strobe(strb));

  eof_flag_logic uut (
    .clk(clk), .rst_b(rst_b), .instr(instr),
    .shift_rotate_group_decoded(ctl[0]), .rotate_right_through_extend(ctl[1]),
    .add_memory_to_accumulator(ctl[2]), .increment_accumulator(ctl[3]),
    .increment_memory_skip_zero(ctl[4]), .set_extend_flag(ctl[5]),
    .zero_extend_shift(ctl[6]), .zero_extend_alter(ctl[7]), .invert_extend_flag(ctl[8]),
    .zero_overflow_flag(ctl[9]), .io_switch_address_select(ctl[10]),
    .write_result_to_acc_a(ctl[11]), .write_result_to_acc_b(ctl[12]),
    .skip_if_overflow_set(ctl[13]), .skip_if_overflow_clear(ctl[14]),
    .phase_three(p3), .transfer_strobe(strb), .carry_out_msb(carry),
    .r_bus(r_bus), .s_bus(s_bus), .t_bus(t_bus),
    .result_fill_bit(fill_bit), .result_fill_lsb(fill_lsb), .result_fill_msb(fill_msb),
    .skip_request(skip), .extend_lamp(ext), .overflow_lamp(ovf)
  );

  // Free-running clock
  always #5 clk = ~clk;

  // Cut a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  // One instruction: inputs held through the whole phase, strobe-cycle outputs sampled
  task automatic op(input logic [14:0] c, input logic cy = 1'b0,
                    input logic [15:0] ins = 16'h0000, input logic [15:0] r = 16'h0000,
                    input logic [15:0] s = 16'h0000, input logic [15:0] t = 16'h0000);
    @(posedge clk);
    ctl   <= c;
    carry <= cy;
    instr <= ins;
    r_bus <= r;
    s_bus <= s;
    t_bus <= t;
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    s_bit  = fill_bit;
    s_lsb  = fill_lsb;
    s_msb  = fill_msb;
    s_skip = skip;
    @(negedge clk);
    s_mid = ext;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : op

  task automatic t_extend_ops;
    op(SE);
    chk("ext", 1'b1, ext);
    op(SE);
    chk("ext", 1'b1, ext);
    op(ZEA);
    chk("ext", 1'b0, ext);
    op(SE);
    op(ZES);
    chk("ext", 1'b0, ext);
    op(INV);
    chk("ext", 1'b1, ext);
    op(INV);
    chk("ext", 1'b0, ext);
  endtask : t_extend_ops

  task automatic t_carry;
    op(ADD, 1'b0);
    chk("ext", 1'b0, ext);
    op(ADD, 1'b1);
    chk("ext", 1'b1, ext);
    op(ADD, 1'b0);
    chk("ext", 1'b1, ext);
    op(ZEA);
    chk("ext", 1'b0, ext);
    op(INC, 1'b1);
    chk("ext", 1'b1, ext);
    op(ZEA);
    // Memory increment-skip blocks the carry and overflow of a concurrent increment
    op(MIS | INC, 1'b1, 16'h0000, 16'h8001, 16'h8001, 16'h0002);
    chk("ext", 1'b0, ext);
    chk("ovf", 1'b0, ovf);
  endtask : t_carry

  task automatic t_rotate;
    op(SE);
    op(GRP | WA, 1'b0, 16'h0180, 16'h0000);
    chk("fill_lsb", 1'b1, s_lsb);
    chk("fill_bit", 1'b1, s_bit);
    chk("fill_msb", 1'b0, s_msb);
    chk("ext mid", 1'b1, s_mid);
    chk("ext", 1'b0, ext);
    op(GRP | WB, 1'b0, 16'h0006, 16'h8000);
    chk("fill_bit", 1'b0, s_bit);
    chk("fill_lsb", 1'b1, s_lsb);
    chk("ext", 1'b1, ext);
    op(GRP | WA, 1'b0, 16'h01c0, 16'h0000);
    chk("fill_lsb", 1'b0, s_lsb);
    chk("ext", 1'b1, ext);
    // Rotate bits without the group decode do nothing
    op(WA, 1'b0, 16'h0180, 16'h0000);
    chk("fill_lsb", 1'b0, s_lsb);
    chk("ext", 1'b1, ext);
    op(GRP | RR | WA, 1'b0, 16'h0000, 16'h7ffe);
    chk("fill_msb", 1'b1, s_msb);
    chk("fill_bit", 1'b1, s_bit);
    chk("fill_lsb", 1'b0, s_lsb);
    chk("ext", 1'b0, ext);
    op(GRP | RR | WB, 1'b0, 16'h0000, 16'h0001);
    chk("ext", 1'b1, ext);
  endtask : t_rotate

  task automatic t_overflow;
    op(ZO);
    chk("ovf", 1'b0, ovf);
    op(ADD, 1'b0, 16'h0000, 16'h0800, 16'h0800, 16'h1000);
    chk("ovf", 1'b0, ovf);
    op(ADD, 1'b0, 16'h0000, 16'h0800, 16'h7fff, 16'h87ff);
    chk("ovf", 1'b1, ovf);
    op(ADD, 1'b0, 16'h0000, 16'h0001, 16'h0001, 16'h0002);
    chk("ovf", 1'b1, ovf);
    op(ZO);
    chk("ovf", 1'b0, ovf);
    op(INC, 1'b1, 16'h0000, 16'h8001, 16'h8001, 16'h0002);
    chk("ovf", 1'b1, ovf);
    op(ZO);
    op(15'h0000, 1'b0, 16'h0040);
    chk("ovf", 1'b0, ovf);
    op(IOA, 1'b0, 16'h0040);
    chk("ovf", 1'b1, ovf);
  endtask : t_overflow

  task automatic t_skip;
    op(SKS);
    chk("skip", 1'b1, s_skip);
    op(SKC);
    chk("skip", 1'b0, s_skip);
    op(ZO);
    op(SKS);
    chk("skip", 1'b0, s_skip);
    op(SKC);
    chk("skip", 1'b1, s_skip);
  endtask : t_skip

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Reset, then the scenarios in turn
  initial begin
    clk       = 1'b0;
    rst_b     = 1'b0;
    go        = 1'b0;
    carry     = 1'b0;
    ctl       = 15'h0000;
    instr     = 16'h0000;
    r_bus     = 16'h0000;
    s_bus     = 16'h0000;
    t_bus     = 16'h0000;
    bad_count = 0;
    compares  = 0;
    cycles    = 0;
    repeat (2) @(posedge clk);
    chk("ext rst", 1'b0, ext);
    chk("ovf rst", 1'b0, ovf);
    rst_b <= 1'b1;
    t_extend_ops();
    t_carry();
    t_rotate();
    t_overflow();
    t_skip();
    results();
  end
endmodule : tb_extend_overflow_flag_logic
